// file: logic/muldiv_regs.vh
`ifndef MULDIV_REGS_VH
`define MULDIV_REGS_VH
// operation codes on the issue port
`define OP_MUL_PAIR   3'h0
`define OP_MUL_ACC    3'h1
`define OP_MUL_SUB    3'h2
`define OP_MUL_GPR    3'h3
`define OP_DIV        3'h4
// multiplier array: 32 bits by 16 bits per pass
`define MUL_CHUNK     16
// divide: iterations left after early-in skipping
`define DIV_ITER_8    6'h09
`define DIV_ITER_16   6'h11
`define DIV_ITER_24   6'h19
`define DIV_ITER_32   6'h20
// divide repeat rate in clocks (latency is one more)
`define DIV_REP_8     6'h0b
`define DIV_REP_16    6'h12
`define DIV_REP_24    6'h19
`define DIV_REP_32    6'h20
// divider counter width and full word width
`define DIV_CNT_W     6
`define WORD_W        32
`endif

// file: logic/muldiv_unit.v
// Summary of operation
// - own pipeline keeps running while integer stalls
// - 32x16 array, passes chosen from second operand
// - full 32-bit second operand takes two passes
// - narrow multiply each clock, wide every other
// - interlock holds back-to-back wide multiplies
// - operand size found from operand values
// - divider produces one quotient bit per clock
// - 8-bit dividend skips 23 iterations
// - 16-bit skips 15, 24-bit skips 7
// - any issue stalls until the last clock of an active divide
// - results kept in high and low registers
// - pair multiplies: latency 1/2, repeat 1/2
// - general register multiply: latency 2/3
// - divide latencies 12, 19, 26, 33 clocks
`include "muldiv_regs.vh"

module muldiv_unit (
   input  wire        REF_CLK,
   input  wire        SRST,
   input  wire        CLK_EN,
   input  wire        ISSUE_VALID,
   input  wire [2:0]  ISSUE_OP,
   input  wire        ISSUE_SIGNED,
   input  wire [31:0] FIRST_SOURCE_OPERAND,
   input  wire [31:0] SECOND_SOURCE_OPERAND,
   output wire        ISSUE_READY,
   output wire [31:0] RESULT_HIGH_REG,
   output wire [31:0] RESULT_LOW_REG,
   output wire [31:0] GENERAL_REGISTER_DATA,
   output wire        GENERAL_REGISTER_VALID,
   output wire        DIVIDE_ACTIVE
);

   // short names for the operands
   wire [31:0] opa = FIRST_SOURCE_OPERAND;
   wire [31:0] opb = SECOND_SOURCE_OPERAND;
   wire        sgn = ISSUE_SIGNED;

   // result pair and pipeline state
   reg  [31:0] hi_q;        // high half of the pair
   reg  [31:0] lo_q;        // low half of the pair
   reg         pass2_q;     // second pass pending
   reg  [32:0] a_q;         // held first operand
   reg  [15:0] bhi_q;       // held upper chunk
   reg         bs_q;        // held upper sign bit
   reg  [63:0] part_q;      // first pass product
   reg  [2:0]  op_q;        // held operation
   reg  [31:0] stage_q;     // general result stage
   reg         stage_v_q;   // stage holds a result
   reg  [31:0] gout_q;      // general result output
   reg         gout_v_q;    // general result strobe

   // divider state
   reg  [5:0]  dcnt_q;      // clocks to writeback
   reg  [5:0]  diter_q;     // iterations this divide
   reg  [31:0] rem_q;       // partial remainder
   reg  [31:0] quo_q;       // dividend / quotient
   reg  [31:0] dvs_q;       // divisor magnitude
   reg         negq_q;      // negate quotient
   reg         negr_q;      // negate remainder

   // issue decode
   wire is_mul = (ISSUE_OP == `OP_MUL_PAIR) |
                 (ISSUE_OP == `OP_MUL_ACC) |
                 (ISSUE_OP == `OP_MUL_SUB) |
                 (ISSUE_OP == `OP_MUL_GPR);
   wire is_div = (ISSUE_OP == `OP_DIV);

   // divide stall
   // only the completing clock of a divide lets a new issue in
   wire div_stall = (dcnt_q > 6'h01);

   // wide interlock
   // the array is busy with the second pass, hold multiplies
   wire mul_stall = pass2_q & is_mul;

   // handshake toward the integer pipeline
   assign ISSUE_READY = ~div_stall & ~mul_stall;

   // an accepted issue, frozen when the clock enable is low
   wire take = ISSUE_VALID & ISSUE_READY & CLK_EN;

   // size detection
   // upper bits of the second operand are pure extension
   wire [16:0] bup = opb[31:15];
   wire b_narrow = sgn ? (&bup | ~|bup) : ~|opb[31:16];
   wire wide = ~b_narrow;

   wire [32:0] a_ext = {sgn & opa[31], opa};
   wire        b_top = sgn & opb[31];

   // multiplier operand select
   reg  [32:0] ma;          // first operand into array
   reg  [16:0] mb;          // 16-bit chunk into array
   always @* begin
      if (pass2_q) begin
         // second pass uses upper chunk with sign
         ma = a_q;
         mb = {bs_q, bhi_q};
      end else if (wide) begin
         // first pass of a wide one: low chunk unsigned
         ma = a_ext;
         mb = {1'b0, opb[15:0]};
      end else begin
         // single pass: chunk carries its own sign
         ma = a_ext;
         mb = {sgn & opb[15], opb[15:0]};
      end
   end

   // the 33x17 signed array
   wire signed [49:0] prod = $signed(ma) * $signed(mb);
   wire [63:0] prod_x = {{14{prod[49]}}, prod};
   wire [63:0] prod_sh = {prod_x[47:0], 16'h0000};

   // full product: merged with first pass when needed
   wire [63:0] full = pass2_q ? prod_sh + part_q : prod_x;

   // multiply finishing at this edge
   wire fin = pass2_q | (take & is_mul & b_narrow);
   wire [2:0] fin_op = pass2_q ? op_q : ISSUE_OP;

   // accumulate or subtract against the pair
   reg  [63:0] pair_d;      // next pair value
   reg         pair_we;     // multiply writes pair
   always @* begin
      pair_we = fin;
      case (fin_op)
         `OP_MUL_PAIR: pair_d = full;
         `OP_MUL_ACC:  pair_d = {hi_q, lo_q} + full;
         `OP_MUL_SUB:  pair_d = {hi_q, lo_q} - full;
         default: begin
            // general register multiply leaves pair alone
            pair_d  = {hi_q, lo_q};
            pair_we = 1'b0;
         end
      endcase
   end

   // divide setup: magnitudes and signs
   wire a_neg = sgn & opa[31];
   wire b_neg = sgn & opb[31];
   wire [31:0] amag = a_neg ? (~opa + 32'h1) : opa;
   wire [31:0] bmag = b_neg ? (~opb + 32'h1) : opb;

   // early-in check on the dividend extension
   wire [24:0] u7  = opa[31:7];
   wire [16:0] u15 = opa[31:15];
   wire [8:0]  u23 = opa[31:23];
   wire f8  = sgn ? (&u7 | ~|u7) : ~|opa[31:8];
   wire f16 = sgn ? (&u15 | ~|u15) : ~|opa[31:16];
   wire f24 = sgn ? (&u23 | ~|u23) : ~|opa[31:24];

   // iterations and repeat rate for this dividend
   reg  [5:0] it_d;         // iterations to run
   reg  [5:0] rep_d;        // clocks until writeback
   always @* begin
      if (f8) begin
         it_d  = `DIV_ITER_8;
         rep_d = `DIV_REP_8;
      end else if (f16) begin
         it_d  = `DIV_ITER_16;
         rep_d = `DIV_REP_16;
      end else if (f24) begin
         it_d  = `DIV_ITER_24;
         rep_d = `DIV_REP_24;
      end else begin
         it_d  = `DIV_ITER_32;
         rep_d = `DIV_REP_32;
      end
   end

   // skipped bits are shifted out before the first step
   wire [5:0]  skip = `DIV_ITER_32 - it_d;
   wire [31:0] quo_init = amag << skip;

   // one bit per clock
   // restoring step: shift in, trial subtract, keep or restore
   wire [32:0] shl   = {rem_q[31:0], quo_q[31]};
   wire [33:0] trial = {1'b0, shl} - {2'b00, dvs_q};
   wire        ge    = ~trial[33];
   wire [32:0] rem_n = ge ? trial[32:0] : shl;
   wire [31:0] quo_n = {quo_q[30:0], ge};

   // step runs in the last diter_q clocks of the count
   wire do_iter = (dcnt_q != 6'h00) & (dcnt_q <= diter_q);
   wire div_wb  = (dcnt_q == 6'h01);

   // sign fixup of the finished divide
   wire [31:0] q_fix = negq_q ? (~quo_n + 32'h1) : quo_n;
   wire [31:0] r_fix = negr_q ? (~rem_n[31:0] + 32'h1)
                              : rem_n[31:0];

   // independent pipeline
   // multiply pass state advances on its own clock, never on
   // the integer pipeline's stall
   always @(posedge REF_CLK) begin
      if (SRST) begin
         pass2_q <= 1'b0;
         a_q     <= 33'h000000000;
         bhi_q   <= 16'h0000;
         bs_q    <= 1'b0;
         part_q  <= 64'h0000000000000000;
         op_q    <= 3'h0;
      end else if (CLK_EN) begin
         // issue rate
         // a wide multiply occupies the array two clocks
         pass2_q <= take & is_mul & wide;
         if (take & is_mul & wide) begin
            // hold what the second pass needs
            a_q    <= a_ext;
            bhi_q  <= opb[31:16];
            bs_q   <= b_top;
            part_q <= prod_x;
            op_q   <= ISSUE_OP;
         end
      end
   end

   // pair latency
   // newest operation wins the pair over a divide writeback
   always @(posedge REF_CLK) begin
      if (SRST) begin
         hi_q <= 32'h00000000;
         lo_q <= 32'h00000000;
      end else if (CLK_EN) begin
         if (pair_we) begin
            // multiply result into the pair
            hi_q <= pair_d[63:32];
            lo_q <= pair_d[31:0];
         end else if (div_wb) begin
            // remainder high, quotient low
            hi_q <= r_fix;
            lo_q <= q_fix;
         end
      end
   end

   // general register latency
   // one stage plus the output flop adds a clock
   always @(posedge REF_CLK) begin
      if (SRST) begin
         stage_q   <= 32'h00000000;
         stage_v_q <= 1'b0;
         gout_q    <= 32'h00000000;
         gout_v_q  <= 1'b0;
      end else if (CLK_EN) begin
         stage_v_q <= fin & (fin_op == `OP_MUL_GPR);
         if (fin & (fin_op == `OP_MUL_GPR)) begin
            // low word of the product
            stage_q <= full[31:0];
         end
         gout_v_q <= stage_v_q;
         if (stage_v_q) begin
            // present to the register file
            gout_q <= stage_q;
         end
      end
   end

   // divide timing
   // counter loaded with the repeat rate, writeback at one
   always @(posedge REF_CLK) begin
      if (SRST) begin
         dcnt_q  <= 6'h00;
         diter_q <= 6'h00;
         rem_q   <= 32'h00000000;
         quo_q   <= 32'h00000000;
         dvs_q   <= 32'h00000000;
         negq_q  <= 1'b0;
         negr_q  <= 1'b0;
      end else if (CLK_EN) begin
         if (take & is_div) begin
            // start a divide
            dcnt_q  <= rep_d;
            diter_q <= it_d;
            rem_q   <= 32'h00000000;
            quo_q   <= quo_init;
            dvs_q   <= bmag;
            negq_q  <= a_neg ^ b_neg;
            negr_q  <= a_neg;
         end else begin
            if (dcnt_q != 6'h00) begin
               // count down toward writeback
               dcnt_q <= dcnt_q - 6'h01;
            end
            if (do_iter) begin
               // one quotient bit
               rem_q <= rem_n[31:0];
               quo_q <= quo_n;
            end
         end
      end
   end

   // outputs
   assign RESULT_HIGH_REG        = hi_q;
   assign RESULT_LOW_REG         = lo_q;
   assign GENERAL_REGISTER_DATA  = gout_q;
   assign GENERAL_REGISTER_VALID = gout_v_q;
   assign DIVIDE_ACTIVE          = (dcnt_q != 6'h00);

endmodule // muldiv_unit

// file: tb/int_pipe_model.sv
module int_pipe_model (
   input  wire        clk,
   input  wire        rdy,
   output reg         vld,
   output reg  [2:0]  op,
   output reg         sg,
   output reg  [31:0] fa,
   output reg  [31:0] fb
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle issue port
   initial begin
      vld = 1'b0;
      op = 3'h5;
      sg = 1'b0;
      fa = 32'h0;
      fb = 32'h0;
   end
   // issue at a falling edge; last drops the request after its take
   task send(input [2:0] o, input s, input [31:0] x, input [31:0] y,
             input last);
      begin
         vld = 1'b1;
         op = o;
         sg = s;
         fa = x;
         fb = y;
         // let the ready decode settle on the new operation
         #1;
         while (!rdy) @(negedge clk);
         @(negedge clk);
         if (last) begin
            vld = 1'b0;
            fa = ~fa;
            fb = ~fb;
         end
      end
   endtask
endmodule // int_pipe_model

// file: tb/muldiv_monitor.sv
module muldiv_monitor (
   input wire        REF_CLK,
   input wire        SRST,
   input wire        CLK_EN,
   input wire        ISSUE_VALID,
   input wire [2:0]  ISSUE_OP,
   input wire        ISSUE_SIGNED,
   input wire [31:0] FIRST_SOURCE_OPERAND,
   input wire [31:0] SECOND_SOURCE_OPERAND,
   input wire        ISSUE_READY,
   input wire [31:0] RESULT_HIGH_REG,
   input wire [31:0] RESULT_LOW_REG,
   input wire [31:0] GENERAL_REGISTER_DATA,
   input wire        GENERAL_REGISTER_VALID,
   input wire        DIVIDE_ACTIVE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SRST);
   wire [31:0] a   = FIRST_SOURCE_OPERAND;   // dividend or multiplicand
   wire [31:0] b   = SECOND_SOURCE_OPERAND;  // divisor or multiplier
   wire        tk  = ISSUE_VALID & ISSUE_READY & CLK_EN;  // request taken
   wire        mul = ISSUE_OP < 3'h4;        // any multiply code
   // second operand needs two passes
   wire        wid = ISSUE_SIGNED ? b[31:15] != {17{b[15]}} : |b[31:16];
   // dividend fits in eight bits
   wire        sm  = ISSUE_SIGNED ? a[31:7] == {25{a[7]}} : ~|a[31:8];
   reg  [63:0] pr_q;                         // unsigned product of last cycle
   // reference product, one cycle behind
   always @(posedge REF_CLK) pr_q <= {32'h0, a} * {32'h0, b};
   sequence div8_run;
      DIVIDE_ACTIVE [*8] ##1 DIVIDE_ACTIVE [*3] ##1 !DIVIDE_ACTIVE;
   endsequence
   sequence gpr_wide;
      !GENERAL_REGISTER_VALID ##1 !GENERAL_REGISTER_VALID
      ##1 GENERAL_REGISTER_VALID;
   endsequence
   a_div_holds_issue: assert property (
      tk && ISSUE_OP == 3'h4 |=> !ISSUE_READY [*8]) else $error("div ready");
   // a frozen clock stretches the run, so that attempt is dropped
   a_div_short_run: assert property (
      disable iff (SRST || !CLK_EN)
      tk && ISSUE_OP == 3'h4 && sm |=> div8_run) else $error("div8 time");
   a_div_end_ready: assert property (
      $fell(DIVIDE_ACTIVE) |-> $past(ISSUE_READY)) else $error("div end");
   a_wide_interlock: assert property (
      tk && mul && wid |=> !(ISSUE_READY && ISSUE_VALID && mul))
      else $error("wide interlock");
   a_narrow_rate: assert property (
      tk && mul && !wid |=> !mul || ISSUE_READY) else $error("narrow rate");
   a_narrow_pair: assert property (
      tk && ISSUE_OP == 3'h0 && !ISSUE_SIGNED && !wid
      |=> {RESULT_HIGH_REG, RESULT_LOW_REG} == pr_q) else $error("pair");
   a_gpr_narrow: assert property (
      tk && ISSUE_OP == 3'h3 && !wid |-> ##2 GENERAL_REGISTER_VALID)
      else $error("gpr narrow");
   a_gpr_wide: assert property (
      tk && ISSUE_OP == 3'h3 && wid |=> gpr_wide) else $error("gpr wide");
endmodule // muldiv_monitor

bind muldiv_unit muldiv_monitor u_mon (.*);

// file: tb/muldiv_unit_tb.sv
`include "muldiv_regs.vh"
module muldiv_unit_tb;
   timeunit 1ns;
   timeprecision 1ns;
   reg         clk = 1'b0;   // 10 MHz clock
   reg         srst = 1'b1;  // synchronous reset
   reg         en = 1'b1;    // clock enable
   wire        vld, sg, rdy, gv, da;
   wire [2:0]  op;
   wire [31:0] fa, fb, hi, lo, gd;
   integer     cyc = 0, t, n;
   integer     miscompares = 0, tests_run = 0;
   muldiv_unit DUT (.REF_CLK(clk), .SRST(srst), .CLK_EN(en),
      .ISSUE_VALID(vld), .ISSUE_OP(op), .ISSUE_SIGNED(sg),
      .FIRST_SOURCE_OPERAND(fa), .SECOND_SOURCE_OPERAND(fb),
      .ISSUE_READY(rdy), .RESULT_HIGH_REG(hi), .RESULT_LOW_REG(lo),
      .GENERAL_REGISTER_DATA(gd), .GENERAL_REGISTER_VALID(gv),
      .DIVIDE_ACTIVE(da));
   int_pipe_model m (.clk(clk), .rdy(rdy), .vld(vld), .op(op), .sg(sg),
      .fa(fa), .fb(fb));
   // clock
   initial forever #50 clk = ~clk;
   task chk(input [63:0] got, input [63:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("compares %0d errors %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // cycle count and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         wrap_up;
      end
   end
   // narrow pair ops back to back, each pair code, signed form
   task t_mul;
      begin
         m.send(`OP_MUL_PAIR, 0, 32'h12345678, 32'h0000abcd, 0);
         t = cyc;
         chk({hi, lo}, 64'h12345678 * 64'habcd);
         m.send(`OP_MUL_ACC, 0, 32'h100, 32'h200, 0);
         chk(cyc - t, 1);
         chk({hi, lo}, 64'h12345678 * 64'habcd + 64'h20000);
         m.send(`OP_MUL_SUB, 0, 32'h10, 32'h10, 0);
         chk({hi, lo}, 64'h12345678 * 64'habcd + 64'h1ff00);
         m.send(`OP_MUL_PAIR, 1, 32'hfffffffd, 32'hfffffffb, 1);
         chk({hi, lo}, 64'hf);
         // one idle cycle after the dropped request
         @(negedge clk);
      end
   endtask
   // two wide multiplies back to back
   task t_wide;
      begin
         m.send(`OP_MUL_PAIR, 0, 32'h3, 32'h00010002, 0);
         t = cyc;
         chk({hi, lo}, 64'hf);
         m.send(`OP_MUL_PAIR, 0, 32'h2, 32'h00020000, 1);
         chk(cyc - t, 2);
         chk({hi, lo}, 64'h30006);
         @(negedge clk);
         chk({hi, lo}, 64'h40000);
         // signed wide accumulate: -2 times -2^31 added to the pair
         m.send(`OP_MUL_ACC, 1, 32'hfffffffe, 32'h80000000, 1);
         chk({hi, lo}, 64'h40000);
         @(negedge clk);
         chk({hi, lo}, 64'h0000000100040000);
      end
   endtask
   // general register multiplies, narrow then wide
   task t_gpr;
      begin
         m.send(`OP_MUL_GPR, 0, 32'h7, 32'h9, 1);
         chk(gv, 0);
         @(negedge clk);
         chk({gv, gd}, {1'b1, 32'h3f});
         chk({hi, lo}, 64'h0000000100040000);
         m.send(`OP_MUL_GPR, 0, 32'h10, 32'h00100001, 1);
         chk(gv, 0);
         @(negedge clk);
         chk(gv, 0);
         @(negedge clk);
         chk({gv, gd}, {1'b1, 32'h01000010});
      end
   endtask
   // one divide: latency counted while the issue port is idle
   task t_div(input [31:0] x, input [31:0] y, input s, input [5:0] lat,
              input [31:0] q, input [31:0] r);
      begin
         m.send(`OP_DIV, s, x, y, 1);
         n = 1;
         while (da && n < 40) begin
            @(negedge clk);
            n = n + 1;
         end
         chk(n, lat);
         chk({hi, lo}, {r, q});
      end
   endtask
   // divide frozen by the clock enable for five clocks
   task t_freeze;
      begin
         m.send(`OP_DIV, 0, 32'h64, 32'h7, 1);
         en = 1'b0;
         repeat (5) @(negedge clk);
         chk({da, rdy}, 2'b10);
         en = 1'b1;
         n = 1;
         while (da && n < 40) begin
            @(negedge clk);
            n = n + 1;
         end
         chk(n, 12);
         chk({hi, lo}, {32'h2, 32'he});
      end
   endtask
   // multiply waits for a running divide, then wins the pair
   task t_stall;
      begin
         m.send(`OP_DIV, 0, 32'h64, 32'h7, 0);
         t = cyc;
         m.send(`OP_MUL_PAIR, 0, 32'h3, 32'h5, 1);
         chk(cyc - t, `DIV_REP_8);
         chk({hi, lo}, 64'hf);
      end
   endtask
   // main sequence
   initial begin
      repeat (20) @(negedge clk);
      srst = 1'b0;
      chk({rdy, da, gv}, 3'h4);
      chk({hi, lo}, 64'h0);
      t_mul;
      t_wide;
      t_gpr;
      t_div(32'h64, 32'h7, 0, 12, 32'he, 32'h2);
      t_div(32'h1234, 32'h7, 0, 19, 32'h299, 32'h5);
      t_div(32'h123456, 32'h7, 0, 26, 32'h299c3, 32'h1);
      t_div(32'h12345678, 32'h7, 0, 33, 32'h299c335, 32'h5);
      t_div(32'hffffff9c, 32'h7, 1, 12, 32'hfffffff2, 32'hfffffffe);
      t_freeze;
      t_stall;
      wrap_up;
   end
endmodule // muldiv_unit_tb
